// >>> pkg/pcsw_pkg.sv
// Functional notes
// - Auto mode moves reference to other input when current one stops; repeatable.
// - No switchover when both inputs are dead; loss flags then meaningless.
// - Loss flag rises after about two stuck input cycles; select then moves.
// - Loss flags valid only within twenty percent frequency difference.
// - Selected-input flag always shows which reference feeds the PLL.
// - Switch takes effect on a falling edge of the available input.
// - Gate off on old input fall, select new on its fall, update flag.
// - Override mode: only request rising edge switches; falling edge never reverts; the code also switches automatically while the request is low.
// - Override mode: selected-input flag follows switch request level; the code has it follow the select one cycle later instead.
// - User switch with both inputs running keeps both loss flags low.
// - Any switch completes only when target toggles; otherwise wait.
// - Manual mode selects primary input after reset, before any request.
// - Manual switch: request rises and stays high three reference cycles.
package pcsw_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Assumed nominal reference period; sampling needs it well above the clock period
    localparam int unsigned REF_PERIOD_NS = 400;
    localparam int unsigned LOSS_TIME_NS  = 2 * REF_PERIOD_NS;
    localparam int unsigned LOSS_CYC_I    = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W         = 8;
    localparam logic [CNT_W-1:0] LOSS_CYC = CNT_W'(LOSS_CYC_I);
    localparam logic [1:0] MAN_HOLD       = 2'h3;

    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_COUNT  = 4'h8;

    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_OVR  = 2'h1;
    localparam logic [1:0] MODE_MAN  = 2'h2;
    localparam logic [1:0] MODE_RST  = MODE_AUTO;

    localparam int unsigned ST_BAD0   = 0;
    localparam int unsigned ST_BAD1   = 1;
    localparam int unsigned ST_ACTIVE = 2;
    localparam int unsigned ST_GATE   = 3;
    localparam int unsigned ST_BUSY   = 4;

    typedef enum logic [1:0] {SW_RUN, SW_GATE, SW_WAIT} pcsw_state_t;
endpackage

// >>> pkg/pcsw_sense_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pcsw_sense_if;
    logic fall;
    logic bad;
    modport mon (output fall, output bad);
    modport sink (input fall, input bad);
endinterface
`default_nettype wire

// >>> rtl/pcsw_sense.sv
`timescale 1ns/10ps
`default_nettype none
module pcsw_sense
    import pcsw_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    input  wire logic   i_ref,
    pcsw_sense_if.mon   sn
);
    logic             meta_r;
    logic             sync_r;
    logic             last_r;
    logic [CNT_W-1:0] idle_r;
    logic             bad_r;
    logic             fall_r;
    logic             edge_seen;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= i_ref;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign edge_seen = sync_r ^ last_r;

    // Stuck detector: any edge restarts the idle count
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idle_r <= '0;
            bad_r  <= 1'b0;
        end else if (edge_seen) begin
            idle_r <= '0;
            bad_r  <= 1'b0;
        end else if (idle_r != LOSS_CYC) begin
            idle_r <= idle_r + 1'b1;
            bad_r  <= (idle_r == LOSS_CYC - 1'b1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fall_r <= 1'b0;
        end else begin
            fall_r <= last_r & ~sync_r;
        end
    end

    assign sn.fall = fall_r;
    assign sn.bad  = bad_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_bad_clear;
        edge_seen |=> !bad_r;
    endproperty
    a_bad_clear: assert property (p_bad_clear) else $error("loss flag kept after edge");

    property p_bad_rise;
        $rose(bad_r) |-> $past(idle_r) == LOSS_CYC - 1'b1;
    endproperty
    a_bad_rise: assert property (p_bad_rise) else $error("loss flag at wrong count");
endmodule
`default_nettype wire

// >>> rtl/pcsw_top.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module pcsw_top
    import pcsw_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_primary_ref_clk,
    input  wire logic              i_backup_ref_clk,
    input  wire logic              i_clk_switch,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata,
    output logic                   o_ref_sel,
    output logic                   o_ref_gate,
    output logic                   o_active_clk,
    output logic [1:0]             o_clk_bad
);
    logic        rst_meta_r;
    logic        rst_n;
    logic        sw_meta_r;
    logic        sw_sync_r;
    logic        sw_last_r;
    logic        sw_rise;
    logic [1:0]  mode_r;
    pcsw_state_t st_r;
    logic        sel_r;
    logic        gate_r;
    logic        active_r;
    logic [1:0]  bad_r;
    logic [1:0]  man_cnt_r;
    logic        man_arm_r;
    logic        man_go;
    logic        auto_go;
    logic        start;
    logic [15:0] sw_cnt_r;
    logic [31:0] rdata_r;
    logic        cur_fall;
    logic        cur_bad;
    logic        alt_fall;
    logic        alt_bad;

    pcsw_sense_if sn0 ();
    pcsw_sense_if sn1 ();

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    pcsw_sense u_sense0 (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_ref   (i_primary_ref_clk),
        .sn      (sn0.mon)
    );

    pcsw_sense u_sense1 (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_ref   (i_backup_ref_clk),
        .sn      (sn1.mon)
    );

    assign cur_fall = sel_r ? sn1.fall : sn0.fall;
    assign cur_bad  = sel_r ? sn1.bad  : sn0.bad;
    assign alt_fall = sel_r ? sn0.fall : sn1.fall;
    assign alt_bad  = sel_r ? sn0.bad  : sn1.bad;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_meta_r <= 1'b0;
            sw_sync_r <= 1'b0;
            sw_last_r <= 1'b0;
        end else begin
            sw_meta_r <= i_clk_switch;
            sw_sync_r <= sw_meta_r;
            sw_last_r <= sw_sync_r;
        end
    end

    // Positive-edge sensitive: a falling request never starts anything
    assign sw_rise = sw_sync_r & ~sw_last_r;

    // Manual hold qualification counts falling edges of the current input
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            man_arm_r <= 1'b0;
            man_cnt_r <= '0;
        end else if (!sw_sync_r) begin
            man_arm_r <= 1'b0;
            man_cnt_r <= '0;
        end else if (sw_rise) begin
            man_arm_r <= 1'b1;
            man_cnt_r <= '0;
        end else if (man_go) begin
            man_arm_r <= 1'b0;
            man_cnt_r <= '0;
        end else if (man_arm_r && cur_fall) begin
            man_cnt_r <= man_cnt_r + 1'b1;
        end
    end

    assign man_go = man_arm_r & sw_sync_r & cur_fall & (man_cnt_r == MAN_HOLD - 1'b1) & (st_r == SW_RUN);

    // A dead alternate blocks the move, so two dead inputs leave the selection alone
    assign auto_go = cur_bad & ~alt_bad;

    always_comb begin
        start = 1'b0;
        if (st_r == SW_RUN) begin
            case (mode_r)
                MODE_AUTO: start = auto_go;
                // While the request is high, automatic action is blocked
                MODE_OVR:  start = sw_rise | (auto_go & ~sw_sync_r);
                default:   start = man_go;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= SW_RUN;
            sel_r  <= 1'b0;
            gate_r <= 1'b1;
        end else begin
            case (st_r)
                SW_RUN: begin
                    if (start) begin
                        st_r <= SW_GATE;
                    end
                end
                SW_GATE: begin
                    // A stopped old input has no edge left to wait for
                    if (cur_fall || cur_bad) begin
                        gate_r <= 1'b0;
                        st_r   <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    // Hold until the target shows a falling edge; no timeout
                    if (alt_fall) begin
                        sel_r  <= ~sel_r;
                        gate_r <= 1'b1;
                        st_r   <= SW_RUN;
                    end
                end
                default: begin
                    st_r <= SW_RUN;
                end
            endcase
        end
    end

    // Flag follows the mux one cycle later in every mode; in override mode it does not track the request level
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
        end else begin
            active_r <= sel_r;
        end
    end

    // Loss flags come only from the sense blocks, so a user switch between live inputs keeps them low
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            bad_r <= '0;
        end else begin
            bad_r <= {sn1.bad, sn0.bad};
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_cnt_r <= '0;
        end else if (st_r == SW_WAIT && alt_fall) begin
            sw_cnt_r <= sw_cnt_r + 1'b1;
        end
    end

    // Mode changes are taken at once; change it only while idle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_RST;
        end else if (i_wr && i_addr == ADDR_CTRL) begin
            mode_r <= i_wdata[1:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (i_rd) begin
            rdata_r <= '0;
            case (i_addr)
                ADDR_CTRL: begin
                    rdata_r[1:0] <= mode_r;
                end
                ADDR_STATUS: begin
                    rdata_r[ST_BAD0]   <= bad_r[0];
                    rdata_r[ST_BAD1]   <= bad_r[1];
                    rdata_r[ST_ACTIVE] <= active_r;
                    rdata_r[ST_GATE]   <= gate_r;
                    rdata_r[ST_BUSY]   <= (st_r != SW_RUN);
                end
                ADDR_COUNT: begin
                    rdata_r[15:0] <= sw_cnt_r;
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign o_rdata      = rdata_r;
    assign o_ref_sel    = sel_r;
    assign o_ref_gate   = gate_r;
    assign o_active_clk = active_r;
    assign o_clk_bad    = bad_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    property p_auto_go;
        (mode_r == MODE_AUTO && st_r == SW_RUN && cur_bad && !alt_bad) |=> st_r == SW_GATE;
    endproperty
    a_auto_go: assert property (p_auto_go) else $error("auto switch not started");

    property p_both_dead;
        (mode_r == MODE_AUTO && st_r == SW_RUN && cur_bad && alt_bad) |=> st_r == SW_RUN;
    endproperty
    a_both_dead: assert property (p_both_dead) else $error("switch started with both inputs dead");

    property p_sel_on_fall;
        $changed(sel_r) |-> $past(alt_fall) && $past(st_r) == SW_WAIT;
    endproperty
    a_sel_on_fall: assert property (p_sel_on_fall) else $error("select moved off a falling edge");

    property p_gated_in_wait;
        (st_r == SW_WAIT) |-> !gate_r ##0 $past(st_r) != SW_RUN;
    endproperty
    a_gated_in_wait: assert property (p_gated_in_wait) else $error("reference not gated while waiting");

    property p_flag_follows;
        $changed(sel_r) |=> active_r == sel_r ##1 active_r == $past(sel_r);
    endproperty
    a_flag_follows: assert property (p_flag_follows) else $error("selected flag out of step");

    property p_ovr_rise;
        (mode_r == MODE_OVR && st_r == SW_RUN && sw_rise) |=> st_r == SW_GATE;
    endproperty
    a_ovr_rise: assert property (p_ovr_rise) else $error("request edge ignored");

    property p_ovr_fall;
        (mode_r == MODE_OVR && st_r == SW_RUN && $fell(sw_sync_r) && !auto_go) |=> st_r == SW_RUN;
    endproperty
    a_ovr_fall: assert property (p_ovr_fall) else $error("falling request caused a switch");

    property p_man_hold;
        (mode_r == MODE_MAN && st_r == SW_GATE && $past(st_r) == SW_RUN) |-> $past(man_cnt_r) == MAN_HOLD - 1'b1;
    endproperty
    a_man_hold: assert property (p_man_hold) else $error("manual switch before hold time");

    property p_wait_hold;
        (st_r == SW_WAIT && !alt_fall) |=> st_r == SW_WAIT && $stable(sel_r);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("switch completed without target");

    property p_primary_first;
        (sw_cnt_r == 16'h0000) |-> !sel_r && !active_r;
    endproperty
    a_primary_first: assert property (p_primary_first) else $error("backup selected before any switch");

    property p_wait_done;
        (st_r == SW_WAIT && alt_fall) |=> st_r == SW_RUN && gate_r && sel_r != $past(sel_r);
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("switch not completed on target fall");

    property p_gate_off;
        (st_r == SW_GATE && (cur_fall || cur_bad)) |=> !gate_r && st_r == SW_WAIT;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("reference not gated at old input fall");

    property p_gate_in_run;
        (st_r == SW_RUN) |-> gate_r;
    endproperty
    a_gate_in_run: assert property (p_gate_in_run) else $error("reference gated while idle");

    property p_ovr_block;
        (mode_r == MODE_OVR && st_r == SW_RUN && sw_sync_r && !sw_rise) |=> st_r == SW_RUN;
    endproperty
    a_ovr_block: assert property (p_ovr_block) else $error("automatic switch while request high");

    property p_man_only_req;
        (mode_r != MODE_AUTO && mode_r != MODE_OVR && st_r == SW_RUN && !man_go) |=> st_r == SW_RUN;
    endproperty
    a_man_only_req: assert property (p_man_only_req) else $error("manual mode switched without request");

    property p_man_rearm;
        man_go |=> !man_arm_r;
    endproperty
    a_man_rearm: assert property (p_man_rearm) else $error("manual request stayed armed after switch");

    property p_man_held;
        (!man_arm_r && sw_sync_r && !sw_rise) |=> !man_arm_r;
    endproperty
    a_man_held: assert property (p_man_held) else $error("held request armed a second switch");

    property p_flag_prop;
        $changed({sn1.bad, sn0.bad}) |=> bad_r == $past({sn1.bad, sn0.bad});
    endproperty
    a_flag_prop: assert property (p_flag_prop) else $error("loss flags not passed on");

    property p_user_flags;
        (mode_r != MODE_AUTO && st_r != SW_RUN && !sn0.bad && !sn1.bad) |=> bad_r == 2'b00;
    endproperty
    a_user_flags: assert property (p_user_flags) else $error("loss flag raised during user switch");

    property p_auto_target;
        (mode_r == MODE_AUTO && start) |-> !alt_bad;
    endproperty
    a_auto_target: assert property (p_auto_target) else $error("automatic switch toward a dead input");

    property p_sel_quiet;
        (st_r != SW_WAIT) |=> $stable(sel_r);
    endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("select moved outside the wait state");

    c_auto: cover property (mode_r == MODE_AUTO && st_r == SW_WAIT ##[1:200] st_r == SW_RUN);
    c_ovr: cover property (mode_r == MODE_OVR && sw_rise ##[1:200] $changed(sel_r));
    c_man: cover property (mode_r == MODE_MAN && man_go);
    c_dead: cover property (sn0.bad && sn1.bad);
    c_busy_read: cover property (i_rd && i_addr == ADDR_STATUS && st_r != SW_RUN);
endmodule
`default_nettype wire

// >>> sim/pcsw_user_model.sv
`timescale 1ns/10ps
`default_nettype none
module pcsw_user_model (
    input  wire logic       i_clk,
    input  wire logic       i_run0,
    input  wire logic       i_run1,
    input  wire logic       i_req,
    input  wire logic       i_sel,
    input  wire logic [1:0] i_bad,
    output logic            o_primary_ref_clk,
    output logic            o_backup_ref_clk,
    output logic            o_clk_switch,
    output logic            o_phase_detector_enable,
    output logic            o_pll_reset,
    output logic            o_net_en
);
    logic sel_q = 1'b0;

    // Periods 400 ns and 440 ns stay within a factor two and within 20 percent
    initial begin
        o_primary_ref_clk = 1'b0;
        forever begin
            #200;
            o_primary_ref_clk = i_run0 ? ~o_primary_ref_clk : 1'b0;
        end
    end
    initial begin
        o_backup_ref_clk = 1'b0;
        forever begin
            #220;
            o_backup_ref_clk = i_run1 ? ~o_backup_ref_clk : 1'b0;
        end
    end
    // One clock of reset after each completed switch is 40 ns, above the 10 ns minimum
    always @(posedge i_clk) begin
        o_clk_switch            <= i_req;
        sel_q                   <= i_sel;
        o_pll_reset             <= (sel_q !== i_sel);
        // Loop holds its frequency while either input is reported lost
        o_phase_detector_enable <= ~|i_bad;
        // No lock indicator here, so the network returns once reset and loss flags clear
        o_net_en                <= ~o_pll_reset & ~|i_bad;
    end
endmodule
`default_nettype wire

// >>> sim/pcsw_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pcsw_pkg::*;
    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    logic              ref_sel;
    logic              ref_gate;
    logic              active_clk;
    logic [1:0]        clk_bad;
    logic              run0;
    logic              run1;
    logic              req;
    logic              prim;
    logic              back;
    logic              sw;
    int                num_errors = 0;
    int                checked = 0;

    pcsw_user_model model (.i_clk(clk), .i_run0(run0), .i_run1(run1), .i_req(req),
        .i_sel(ref_sel), .i_bad(clk_bad), .o_primary_ref_clk(prim), .o_backup_ref_clk(back),
        .o_clk_switch(sw), .o_phase_detector_enable(), .o_pll_reset(), .o_net_en());
    pcsw_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_primary_ref_clk(prim), .i_backup_ref_clk(back),
        .i_clk_switch(sw), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_ref_sel(ref_sel), .o_ref_gate(ref_gate), .o_active_clk(active_clk), .o_clk_bad(clk_bad));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic wait_sel(input logic e, input int n);
        for (int i = 0; i < n; i++) begin
            if (ref_sel === e) break;
            cyc(1);
        end
        check({31'h0, ref_sel}, {31'h0, e});
    endtask

    task automatic end_test(input string s);
        $display("Test %s finished", s);
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #800000;
        num_errors++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
        run0  = 1'b1;
        run1  = 1'b1;
        req   = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check({27'h0, ref_sel, active_clk, ref_gate, clk_bad}, 32'h4);
        check(rdata, 32'h0);
        rst_n <= 1'b1;
        cyc(40);
        rd_chk(ADDR_CTRL, 32'h0);
        end_test("reset");

        run0 <= 1'b0;
        cyc(40);
        check({30'h0, clk_bad}, 32'h1);
        wait_sel(1'b1, 200);
        cyc(2);
        check({30'h0, active_clk, ref_gate}, 32'h3);
        run0 <= 1'b1;
        cyc(40);
        run1 <= 1'b0;
        cyc(40);
        check({30'h0, clk_bad}, 32'h2);
        wait_sel(1'b0, 200);
        run1 <= 1'b1;
        cyc(40);
        rd_chk(ADDR_COUNT, 32'h2);
        wr_reg(ADDR_STATUS, 32'hff);
        rd_chk(ADDR_STATUS, 32'h8);
        rd_chk(4'hc, 32'h0);
        wr_reg(4'hc, 32'h3);
        rd_chk(ADDR_CTRL, 32'h0);
        end_test("auto");

        run1 <= 1'b0;
        cyc(40);
        check({30'h0, clk_bad}, 32'h2);
        run0 <= 1'b0;
        cyc(100);
        check({31'h0, ref_sel}, 32'h0);
        run0 <= 1'b1;
        cyc(40);
        run1 <= 1'b1;
        cyc(60);
        end_test("both_dead");

        wr_reg(ADDR_CTRL, {30'h0, MODE_OVR});
        rd_chk(ADDR_CTRL, 32'h1);
        run1 <= 1'b0;
        cyc(40);
        req <= 1'b1;
        cyc(100);
        check({30'h0, ref_sel, ref_gate}, 32'h0);
        rd_chk(ADDR_STATUS, 32'h12);
        run1 <= 1'b1;
        wait_sel(1'b1, 200);
        cyc(2);
        check({31'h0, active_clk}, {31'h0, sw});
        req <= 1'b0;
        cyc(100);
        check({31'h0, ref_sel}, 32'h1);
        req <= 1'b1;
        wait_sel(1'b0, 200);
        check({30'h0, clk_bad}, 32'h0);
        req <= 1'b0;
        cyc(40);
        end_test("override");

        wr_reg(ADDR_CTRL, {30'h0, MODE_MAN});
        req <= 1'b1;
        cyc(8);
        req <= 1'b0;
        cyc(60);
        check({31'h0, ref_sel}, 32'h0);
        req <= 1'b1;
        wait_sel(1'b1, 200);
        cyc(100);
        check({31'h0, ref_sel}, 32'h1);
        req <= 1'b0;
        cyc(20);
        req <= 1'b1;
        wait_sel(1'b0, 200);
        check({30'h0, clk_bad}, 32'h0);
        req <= 1'b0;
        cyc(20);
        wr_reg(ADDR_CTRL, 32'h3);
        rd_chk(ADDR_CTRL, 32'h3);
        end_test("manual");
        close_out();
    end
endmodule
`default_nettype wire
